// ===== motorless_consts.vh
// constants for the motorless test mode control block
`ifndef MOTORLESS_CONSTS_VH
`define MOTORLESS_CONSTS_VH
// ----------------------------------------
// register map
// ----------------------------------------
`define ADDR_SETUP        4'h0
`define ADDR_STATUS       4'h1
`define ADDR_FUNC_REQ     4'h2
`define ADDR_FUNC_RESULT  4'h3
`define ADDR_SIM_POS      4'h4
`define SETUP_RESET       16'h0000
// ----------------------------------------
// setup digit fields (one hex digit each)
// ----------------------------------------
`define DIG_ENABLE_LSB    0
`define DIG_RES_LSB       4
`define DIG_TYPE_LSB      8
// ----------------------------------------
// utility function codes
// ----------------------------------------
`define FN_MTURN_RESET    12'h008
`define FN_CUR_OFS_AUTO   12'h00E
`define FN_CUR_OFS_MAN    12'h00F
`define FN_MTURN_LIMIT    12'h013
`define FN_VIB_DET_INIT   12'h01B
`define FN_ORIGIN_SET     12'h020
`define FN_TUNE_FIRST     12'h200
`define FN_TUNE_LAST      12'h207
// ----------------------------------------
// status display codes
// ----------------------------------------
`define ST_RUN            3'h0
`define ST_BB             3'h1
`define ST_PTNT           3'h2
`define ST_POT            3'h3
`define ST_NOT            3'h4
`define ST_HBB            3'h5
`define ST_ALARM          3'h7
// ----------------------------------------
// resolutions
// ----------------------------------------
`define RES_LOW_BITS      5'h0D
`define RES_HIGH_BITS     5'h14
`endif

// ===== func_gate.v
// utility function permission check during the motorless test
`timescale 1ns/1ps
`include "motorless_consts.vh"
module func_gate (
    input  wire        test_active,
    input  wire        motor_absent,
    input  wire [11:0] func_code,
    output reg         func_allowed
);
    always @* begin
        func_allowed = 1'b1;
        if (test_active) begin
            if (func_code == `FN_VIB_DET_INIT)
                func_allowed = 1'b0;
            else if (func_code >= `FN_TUNE_FIRST && func_code <= `FN_TUNE_LAST)
                func_allowed = 1'b0;
            else if (motor_absent && (func_code == `FN_MTURN_RESET || func_code == `FN_CUR_OFS_AUTO ||
                     func_code == `FN_CUR_OFS_MAN || func_code == `FN_MTURN_LIMIT ||
                     func_code == `FN_ORIGIN_SET))
                func_allowed = 1'b0;
            // analog monitor adjust, jog, origin search and the rest pass in both cases
        end
    end
endmodule

// ===== sim_encoder.v
// simulated encoder: feedback follows command at the chosen resolution
`timescale 1ns/1ps
`include "motorless_consts.vh"
module sim_encoder #(
    parameter W = 32
) (
    input  wire         mclk,
    input  wire         reset_n,
    input  wire         run,
    input  wire         res_high,
    input  wire         absolute,
    input  wire [W-1:0] cmd_pos,
    output reg  [W-1:0] fb_pos,
    output reg  [4:0]   fb_bits,
    output reg          fb_absolute
);
    // ----------------------------------------
    // feedback tracking
    // ----------------------------------------
    always @(posedge mclk) begin
        if (!reset_n) begin
            fb_pos      <= {W{1'b0}};
            fb_bits     <= `RES_LOW_BITS;
            fb_absolute <= 1'b0;
        end else begin
            fb_bits     <= res_high ? `RES_HIGH_BITS : `RES_LOW_BITS;
            fb_absolute <= absolute;
            // incremental feedback restarts from zero while idle; absolute keeps position
            if (run)
                fb_pos <= cmd_pos;
            else if (!absolute)
                fb_pos <= {W{1'b0}};
        end
    end
endmodule

// ===== motorless_test_ctrl.v
// motorless test mode control: setup, inhibits, function gate and display
`timescale 1ns/1ps
`include "motorless_consts.vh"
module motorless_test_ctrl #(
    parameter POS_W = 32
) (
    input  wire             mclk,
    input  wire             reset_n,
    input  wire [3:0]       addr,
    input  wire [15:0]      wdata,
    input  wire             wr,
    input  wire             rd,
    output reg  [15:0]      rdata,
    input  wire             restart,
    input  wire             encoder_connected,
    input  wire             ext_encoder_used,
    input  wire             servo_on,
    input  wire             fwd_inhibit,
    input  wire             rev_inhibit,
    input  wire             safety_bb,
    input  wire             alarm_active,
    input  wire             regen_req,
    input  wire             dyn_brake_req,
    input  wire             brake_req,
    input  wire [POS_W-1:0] cmd_pos,
    output wire             regen_en,
    output wire             dyn_brake_en,
    output wire             brake_out,
    output wire             brake_monitor,
    output reg              test_active,
    output reg              disp_prefix,
    output reg  [2:0]       disp_status,
    output wire [POS_W-1:0] fb_pos,
    output wire [4:0]       fb_bits,
    output wire             fb_absolute,
    output wire             ext_fb_absolute
);
    // ----------------------------------------
    // setup register and latched copy
    // ----------------------------------------
    reg  [15:0] setup_q;
    reg         res_high_q;
    reg         abs_q;
    reg         started_conn_q;
    reg         motor_absent_q;
    reg         conn_prev_q;
    reg  [11:0] func_q;
    reg         func_ok_q;
    wire        func_ok;

    always @(posedge mclk) begin
        if (!reset_n)
            setup_q <= `SETUP_RESET;
        else if (wr && addr == `ADDR_SETUP)
            setup_q <= wdata;
    end

    // settings only latch at restart (reset clears them to zero), so a write waits for restart
    always @(posedge mclk) begin
        if (!reset_n) begin
            test_active <= 1'b0;
            res_high_q  <= 1'b0;
            abs_q       <= 1'b0;
        end else if (restart) begin
            test_active <= setup_q[`DIG_ENABLE_LSB +: 4] == 4'h1;
            res_high_q  <= setup_q[`DIG_RES_LSB +: 4] == 4'h1;
            abs_q       <= setup_q[`DIG_TYPE_LSB +: 4] == 4'h1;
        end
    end

    // ----------------------------------------
    // encoder cable history
    // ----------------------------------------
    always @(posedge mclk) begin
        if (!reset_n) begin
            conn_prev_q    <= 1'b0;
            started_conn_q <= 1'b0;
            motor_absent_q <= 1'b1;
        end else begin
            conn_prev_q <= encoder_connected;
            if (restart) begin
                started_conn_q <= encoder_connected;
                motor_absent_q <= !encoder_connected;
            end else if (test_active && started_conn_q && conn_prev_q && !encoder_connected)
                motor_absent_q <= 1'b1;
        end
    end

    // ----------------------------------------
    // inhibits
    // ----------------------------------------
    assign regen_en        = regen_req && !test_active;
    assign dyn_brake_en    = dyn_brake_req && !test_active;
    assign brake_out       = brake_req && !test_active;
    assign brake_monitor   = brake_req;
    assign ext_fb_absolute = ext_encoder_used && !test_active && abs_q;

    // ----------------------------------------
    // utility function gate
    // ----------------------------------------
    func_gate u_gate (
        .test_active  (test_active),
        .motor_absent (motor_absent_q),
        .func_code    (func_q),
        .func_allowed (func_ok)
    );

    always @(posedge mclk) begin
        if (!reset_n) begin
            func_q    <= 12'h000;
            func_ok_q <= 1'b0;
        end else begin
            if (wr && addr == `ADDR_FUNC_REQ)
                func_q <= wdata[11:0];
            func_ok_q <= func_ok;
        end
    end

    // ----------------------------------------
    // simulated encoder
    // ----------------------------------------
    // the simulation never looks at the real cable, so it acts the same either way
    sim_encoder #(
        .W (POS_W)
    ) u_enc (
        .mclk        (mclk),
        .reset_n     (reset_n),
        .run         (test_active && servo_on),
        .res_high    (res_high_q),
        .absolute    (abs_q),
        .cmd_pos     (cmd_pos),
        .fb_pos      (fb_pos),
        .fb_bits     (fb_bits),
        .fb_absolute (fb_absolute)
    );

    // ----------------------------------------
    // display
    // ----------------------------------------
    always @(posedge mclk) begin
        if (!reset_n) begin
            disp_prefix <= 1'b0;
            disp_status <= `ST_BB;
        end else begin
            disp_prefix <= test_active && !alarm_active;
            if (alarm_active)
                disp_status <= `ST_ALARM;
            else if (safety_bb)
                disp_status <= `ST_HBB;
            else if (fwd_inhibit && rev_inhibit)
                disp_status <= `ST_PTNT;
            else if (fwd_inhibit)
                disp_status <= `ST_POT;
            else if (rev_inhibit)
                disp_status <= `ST_NOT;
            else if (servo_on)
                disp_status <= `ST_RUN;
            else
                disp_status <= `ST_BB;
        end
    end

    // ----------------------------------------
    // register read
    // ----------------------------------------
    always @(posedge mclk) begin
        if (!reset_n)
            rdata <= 16'h0000;
        else if (rd) begin
            case (addr)
                `ADDR_SETUP:       rdata <= setup_q;
                `ADDR_STATUS:      rdata <= {9'h000, motor_absent_q, abs_q, res_high_q, brake_req,
                                             disp_prefix, 1'b0, test_active};
                `ADDR_FUNC_REQ:    rdata <= {4'h0, func_q};
                `ADDR_FUNC_RESULT: rdata <= {15'h0000, func_ok_q};
                `ADDR_SIM_POS:     rdata <= fb_pos[15:0];
                default:           rdata <= 16'h0000;
            endcase
        end else
            rdata <= 16'h0000;
    end
endmodule

// ===== host_model.sv
// host controller model: register bus master tasks
`timescale 1ns/1ps
module host_model (
    input  wire logic        mclk,
    output logic [3:0]       addr,
    output logic [15:0]      wdata,
    output logic             wr,
    output logic             rd,
    input  wire logic [15:0] rdata
);
    initial begin
        addr = 4'h0;
        wdata = 16'h0000;
        wr = 1'b0;
        rd = 1'b0;
    end
    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
        wdata <= ~d;
    endtask
    // read data stand only in the cycle after the strobe, so sample just past that edge
    task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
endmodule

// ===== motorless_test_ctrl_sva.sv
// checker for the motorless test mode control block
`timescale 1ns/1ps
module motorless_test_ctrl_sva (
    input wire logic        mclk,
    input wire logic        reset_n,
    input wire logic        rd,
    input wire logic [15:0] rdata,
    input wire logic        restart,
    input wire logic        alarm_active,
    input wire logic        regen_req,
    input wire logic        dyn_brake_req,
    input wire logic        brake_req,
    input wire logic        regen_en,
    input wire logic        dyn_brake_en,
    input wire logic        brake_out,
    input wire logic        brake_monitor,
    input wire logic        test_active,
    input wire logic        disp_prefix,
    input wire logic [2:0]  disp_status,
    input wire logic        ext_fb_absolute
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);
    a_active_on_restart: assert property (!restart |=> $stable(test_active)) else $error("mode moved without restart");
    a_regen_inhibit: assert property (regen_en == (regen_req && !test_active)) else $error("regen gate wrong");
    a_dynbrk_inhibit: assert property (dyn_brake_en == (dyn_brake_req && !test_active)) else $error("db gate wrong");
    a_brake_inhibit: assert property (brake_out == (brake_req && !test_active)) else $error("brake gate wrong");
    a_brake_visible: assert property (brake_monitor == brake_req) else $error("brake monitor wrong");
    a_ext_incremental: assert property (test_active |-> !ext_fb_absolute) else $error("ext fb absolute");
    a_prefix_shown: assert property (test_active && !alarm_active |=> disp_prefix) else $error("no prefix");
    a_alarm_hides: assert property (alarm_active |=> !disp_prefix && disp_status == 3'h7) else $error("alarm shown wrong");
    a_rdata_idle: assert property (!rd |=> rdata == 16'h0000) else $error("rdata not idle");
    c_restart: cover property (restart ##1 test_active);
    c_alarm: cover property (test_active && alarm_active);
    c_read: cover property (rd ##1 rdata != 16'h0000);
endmodule

// ===== testbench.sv
// self-checking testbench for the motorless test mode control block
`timescale 1ns/1ps
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin fails++; \
    $display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp); end end
module testbench;
    logic mclk = 0, reset_n = 0, restart = 0, enc = 1, ext_enc = 1, servo_on = 0, fwd = 0, rev = 0;
    logic sbb = 0, alarm = 0, rq_regen = 1, rq_db = 1, rq_brk = 1;
    logic [31:0] cmd_pos = 32'h0000_1234;
    logic [3:0] addr;
    logic [15:0] wdata, rdata, d;
    logic wr, rd, regen_en, db_en, brk_out, brk_mon, active, prefix, fb_abs, ext_abs;
    logic [2:0] status;
    logic [31:0] fb_pos;
    logic [4:0] fb_bits;
    int fails = 0, samples_checked = 0;
    initial forever #50 mclk = ~mclk;
    host_model host_u (.mclk(mclk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
    motorless_test_ctrl dut_u (.mclk(mclk), .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .restart(restart), .encoder_connected(enc), .ext_encoder_used(ext_enc),
        .servo_on(servo_on), .fwd_inhibit(fwd), .rev_inhibit(rev), .safety_bb(sbb), .alarm_active(alarm),
        .regen_req(rq_regen), .dyn_brake_req(rq_db), .brake_req(rq_brk), .cmd_pos(cmd_pos),
        .regen_en(regen_en), .dyn_brake_en(db_en), .brake_out(brk_out), .brake_monitor(brk_mon),
        .test_active(active), .disp_prefix(prefix), .disp_status(status), .fb_pos(fb_pos),
        .fb_bits(fb_bits), .fb_absolute(fb_abs), .ext_fb_absolute(ext_abs));
    task automatic pulse_restart();
        @(posedge mclk) restart <= 1'b1;
        @(posedge mclk) restart <= 1'b0;
        repeat (3) @(posedge mclk);
        #1;
    endtask
    // setup written but restart not yet given: mode must stay off
    task automatic t_setup();
        host_u.rd_reg(4'h0, d);
        `CHK(d, 16'h0000)
        host_u.rd_reg(4'hF, d);
        `CHK(d, 16'h0000)
        host_u.wr_reg(4'h0, 16'h0111);
        repeat (3) @(posedge mclk);
        #1 `CHK(active, 1'b0)
        `CHK(regen_en, 1'b1)
        pulse_restart();
        `CHK(active, 1'b1)
        `CHK({regen_en, db_en, brk_out, brk_mon}, 4'h1)
        `CHK(fb_bits, 5'h14)
        `CHK(fb_abs, 1'b1)
        `CHK(ext_abs, 1'b0)
        `CHK({prefix, status}, 4'h9)
        host_u.rd_reg(4'h1, d);
        `CHK(d, 16'h003D)
        // feedback only tracks while the simulated motor is powered
        @(posedge mclk) servo_on <= 1'b1;
        repeat (2) @(posedge mclk);
        #1 `CHK(fb_pos, 32'h0000_1234)
        `CHK({prefix, status}, 4'h8)
    endtask
    task automatic t_display();
        @(posedge mclk) sbb <= 1'b1;
        repeat (2) @(posedge mclk);
        #1 `CHK({prefix, status}, 4'hD)
        @(posedge mclk) alarm <= 1'b1;
        repeat (2) @(posedge mclk);
        #1 `CHK({prefix, status}, 4'h7)
        @(posedge mclk) {alarm, sbb, fwd, rev} <= 4'h3;
        repeat (2) @(posedge mclk);
        #1 `CHK({prefix, status}, 4'hA)
        @(posedge mclk) rev <= 1'b0;
        repeat (2) @(posedge mclk);
        #1 `CHK({prefix, status}, 4'hB)
        @(posedge mclk) {fwd, rev} <= 2'b01;
        repeat (2) @(posedge mclk);
        #1 `CHK({prefix, status}, 4'hC)
        @(posedge mclk) rev <= 1'b0;
    endtask
    task automatic chk_fn(input logic [11:0] code, input logic ok);
        host_u.wr_reg(4'h2, {4'h0, code});
        repeat (2) @(posedge mclk);
        host_u.rd_reg(4'h3, d);
        `CHK(d[0], ok)
    endtask
    // cable dropped after starting connected narrows the allowed set
    task automatic t_funcs();
        chk_fn(12'h01B, 1'b0);
        chk_fn(12'h200, 1'b0);
        chk_fn(12'h207, 1'b0);
        chk_fn(12'h008, 1'b1);
        @(posedge mclk) enc <= 1'b0;
        repeat (2) @(posedge mclk);
        enc <= 1'b1;
        chk_fn(12'h008, 1'b0);
        chk_fn(12'h020, 1'b0);
        chk_fn(12'h00C, 1'b1);
        chk_fn(12'h00D, 1'b1);
    endtask
    // reset in mid-run: mode drops and setup returns to its factory default
    task automatic t_reset();
        @(posedge mclk) reset_n <= 1'b0;
        repeat (2) @(posedge mclk);
        reset_n <= 1'b1;
        #1 `CHK({active, prefix, status}, 5'h01)
        host_u.rd_reg(4'h0, d);
        `CHK({d, active}, 17'h00000)
    endtask
    task automatic final_report();
        $display("checked %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge mclk);
        reset_n <= 1'b1;
        t_setup();
        t_display();
        t_funcs();
        t_reset();
        final_report();
    end
    initial begin
        #400000;
        fails++;
        final_report();
    end
endmodule
bind motorless_test_ctrl motorless_test_ctrl_sva chk_u (.mclk(mclk), .reset_n(reset_n), .rd(rd), .rdata(rdata),
    .restart(restart), .alarm_active(alarm_active), .regen_req(regen_req), .dyn_brake_req(dyn_brake_req),
    .brake_req(brake_req), .regen_en(regen_en), .dyn_brake_en(dyn_brake_en), .brake_out(brake_out),
    .brake_monitor(brake_monitor), .test_active(test_active), .disp_prefix(disp_prefix),
    .disp_status(disp_status), .ext_fb_absolute(ext_fb_absolute));
